//--- design/odct_decoder.sv
`timescale 1ns/10ps
`default_nettype none
`include "odct_map.svh"
module odct_decoder (
  input  wire logic              clk,          // processor clock, 100 MHz
  input  wire logic              rst_n,        // synchronous reset, active low
  input  wire logic              q_valid,      // queue offers a byte
  input  wire logic [7:0]        q_byte,       // instruction byte from the queue
  input  wire logic [15:0]       count_reg,    // repeat count from the execution unit
  output logic                   q_ready,      // decoder takes the byte
  output logic                   exec_valid,   // one-cycle issue pulse
  output odct_pkg::odct_op_e     exec_op,      // decoded operation
  output logic                   exec_word,    // 1 word, 0 byte
  output logic                   exec_mem,     // modrm names memory
  output logic                   exec_seg_ovr, // segment override active
  output logic [1:0]             exec_seg,     // 0 extra, 1 code, 2 stack, 3 data
  output logic                   exec_rep,     // repeat prefix seen
  output logic [7:0]             exec_modrm,   // modrm byte
  output logic [15:0]            exec_disp,    // displacement, sign-extended
  output logic [15:0]            exec_imm,     // immediate, sized by w or s
  output logic [19:0]            exec_cycles,  // minimum clock count issued
  output logic                   exec_done,    // one-cycle end of execution
  output logic                   exec_illegal, // one-cycle bad encoding pulse
  output logic                   busy          // execution in progress
);
  odct_pkg::odct_dec_s s_q;
  odct_pkg::odct_dec_s d;
  logic                acc;
  odct_tmr_if          tif ();

  odct_timer u_tmr (
    .clk   (clk),
    .rst_n (rst_n),
    .tif   (tif)
  );

  // ****************************************
  // minimum cycle table
  // ****************************************
  function automatic logic [19:0] cyc_f(odct_pkg::odct_op_e op, logic m, logic w, logic repeat_prefix,
                                        logic [15:0] n);
    logic [19:0] c;
    c = `ODCT_CYC_BSX;
    case (op)
      odct_pkg::op_seg_ovr:                c = `ODCT_CYC_SEG_PFX; // [RULE1]
      odct_pkg::op_seg_load:               c = m ? `ODCT_CYC_SEG_LDM : `ODCT_CYC_SEG_LDR; // [RULE2]
      odct_pkg::op_seg_store:              c = m ? `ODCT_CYC_SEG_STM : `ODCT_CYC_SEG_STR; // [RULE3]
      odct_pkg::op_table_translate:        c = `ODCT_CYC_XLT; // [RULE4]
      odct_pkg::op_load_effective_address: c = `ODCT_CYC_LEA; // [RULE5]
      odct_pkg::op_load_pointer_data_seg,
      odct_pkg::op_load_pointer_extra_seg: c = `ODCT_CYC_LPTR; // [RULE6] [RULE7]
      odct_pkg::op_flags_to_high_acc:      c = `ODCT_CYC_F2AH; // [RULE8]
      odct_pkg::op_high_acc_to_flags:      c = `ODCT_CYC_AH2F; // [RULE9]
      odct_pkg::op_negate, odct_pkg::op_invert,
      odct_pkg::op_test_rm:                c = m ? `ODCT_CYC_UN_M : `ODCT_CYC_UN_R; // [RULE10]
      odct_pkg::op_test_imm_rm:            c = m ? `ODCT_CYC_UN_M : `ODCT_CYC_TIMM_R;
      odct_pkg::op_test_acc:               c = w ? `ODCT_CYC_TACC_W : `ODCT_CYC_TACC_B; // [RULE19]
      odct_pkg::op_unpacked_adjust_add:    c = `ODCT_CYC_UAA; // [RULE11]
      odct_pkg::op_packed_adjust_add:      c = `ODCT_CYC_PAA; // [RULE12]
      odct_pkg::op_unsigned_multiply:      c = m ? (w ? `ODCT_CYC_MUL_MW : `ODCT_CYC_MUL_MB)
                                                 : (w ? `ODCT_CYC_MUL_RW : `ODCT_CYC_MUL_RB); // [RULE13]
      odct_pkg::op_signed_multiply:        c = m ? (w ? `ODCT_CYC_SIGNED_MULTIPLY_MW : `ODCT_CYC_SIGNED_MULTIPLY_MB)
                                                 : (w ? `ODCT_CYC_SIGNED_MULTIPLY_RW : `ODCT_CYC_SIGNED_MULTIPLY_RB); // [RULE14]
      odct_pkg::op_signed_multiply_imm:    c = m ? `ODCT_CYC_IMI_M : `ODCT_CYC_IMI_R; // [RULE15]
      odct_pkg::op_unsigned_divide:        c = m ? (w ? `ODCT_CYC_DIV_MW : `ODCT_CYC_DIV_MB)
                                                 : (w ? `ODCT_CYC_DIV_RW : `ODCT_CYC_DIV_RB);
      odct_pkg::op_signed_divide:          c = m ? (w ? `ODCT_CYC_SIGNED_DIVIDE_MW : `ODCT_CYC_SIGNED_DIVIDE_MB)
                                                 : (w ? `ODCT_CYC_SIGNED_DIVIDE_RW : `ODCT_CYC_SIGNED_DIVIDE_RB); // [RULE16]
      odct_pkg::op_unpacked_adjust_divide: c = `ODCT_CYC_UAD; // [RULE17]
      odct_pkg::op_byte_sign_extend:       c = `ODCT_CYC_BSX; // [RULE18]
      odct_pkg::op_string_move:            c = repeat_prefix ? `ODCT_CYC_REP_BAS + {1'b0, n, 3'b000}
                                                   : `ODCT_CYC_STRING_MOVE; // [RULE21] [RULE22]
      default:                             c = `ODCT_CYC_BSX;
    endcase
    return c; // minimum only; queue gaps and waits stretch issue, not this figure [RULE24]
  endfunction : cyc_f

  // ****************************************
  // decode sequence
  // ****************************************
  always_comb begin
    d            = s_q;
    acc          = q_valid && s_q.q_ready;
    d.exec_valid = 1'b0;
    d.exec_done  = 1'b0;
    d.illegal    = 1'b0;
    d.start      = 1'b0;
    case (s_q.st)
      odct_pkg::st_opc: begin
        if (acc) begin
          d.opc     = q_byte;
          d.modrm   = 8'h00;
          d.disp    = 16'h0000;
          d.imm     = 16'h0000;
          d.disp_n  = 3'h0;
          d.imm_n   = 3'h0;
          d.ext_idx = 3'h0;
          d.mem     = 1'b0;
          d.w       = 1'b1;
          d.st      = odct_pkg::st_issue;
          casez (q_byte)
            `ODCT_PFX_SEG: begin
              d.op      = odct_pkg::op_seg_ovr;
              d.seg_ovr = 1'b1; // [RULE1]
              d.seg     = q_byte[4:3];
            end
            `ODCT_PFX_REP: begin
              d.repeat_prefix = 1'b1; // [RULE22]
              d.st  = odct_pkg::st_opc;
            end
            `ODCT_OP_SEG_LD: begin
              d.op = odct_pkg::op_seg_load;
              d.st = odct_pkg::st_modrm;
            end
            `ODCT_OP_SEG_ST: begin
              d.op = odct_pkg::op_seg_store;
              d.st = odct_pkg::st_modrm;
            end
            `ODCT_OP_LEA: begin
              d.op = odct_pkg::op_load_effective_address;
              d.st = odct_pkg::st_modrm;
            end
            `ODCT_OP_LDS: begin
              d.op = odct_pkg::op_load_pointer_data_seg;
              d.st = odct_pkg::st_modrm;
            end
            `ODCT_OP_LES: begin
              d.op = odct_pkg::op_load_pointer_extra_seg;
              d.st = odct_pkg::st_modrm;
            end
            `ODCT_OP_TST_RM: begin
              d.op = odct_pkg::op_test_rm;
              d.w  = q_byte[0];
              d.st = odct_pkg::st_modrm;
            end
            `ODCT_OP_GRP: begin
              d.w  = q_byte[0];
              d.st = odct_pkg::st_modrm;
            end
            `ODCT_OP_IMUL3: begin
              d.op = odct_pkg::op_signed_multiply_imm;
              d.st = odct_pkg::st_modrm;
            end
            `ODCT_OP_TST_ACC: begin
              d.op    = odct_pkg::op_test_acc;
              d.w     = q_byte[0];
              d.imm_n = q_byte[0] ? 3'h2 : 3'h1; // [RULE23]
              d.st    = odct_pkg::st_ext;
            end
            `ODCT_OP_UAD: begin
              d.op = odct_pkg::op_unpacked_adjust_divide;
              d.st = odct_pkg::st_sub;
            end
            `ODCT_OP_STRING_MOVE: begin
              d.op = odct_pkg::op_string_move;
              d.w  = q_byte[0]; // [RULE23]
            end
            `ODCT_OP_XLT:  d.op = odct_pkg::op_table_translate;
            `ODCT_OP_F2AH: d.op = odct_pkg::op_flags_to_high_acc;
            `ODCT_OP_AH2F: d.op = odct_pkg::op_high_acc_to_flags;
            `ODCT_OP_UAA:  d.op = odct_pkg::op_unpacked_adjust_add;
            `ODCT_OP_PAA:  d.op = odct_pkg::op_packed_adjust_add;
            `ODCT_OP_BSX:  d.op = odct_pkg::op_byte_sign_extend;
            default: begin
              d.op      = odct_pkg::op_none;
              d.illegal = 1'b1;
              d.seg_ovr = 1'b0;
              d.repeat_prefix     = 1'b0;
              d.st      = odct_pkg::st_opc;
            end
          endcase
        end
      end
      odct_pkg::st_sub: begin
        if (acc) begin
          d.st = odct_pkg::st_issue;
          if (q_byte != `ODCT_UAD_2ND) begin
            d.illegal = 1'b1;
            d.seg_ovr = 1'b0;
            d.repeat_prefix     = 1'b0;
            d.st      = odct_pkg::st_opc;
          end
        end
      end
      odct_pkg::st_modrm: begin
        if (acc) begin
          d.modrm  = q_byte;
          d.mem    = (q_byte[7:6] != 2'b11);
          d.disp_n = (q_byte[7:6] == 2'b01) ? 3'h1 :
                     ((q_byte[7:6] == 2'b10) || (q_byte[7:6] == 2'b00 && q_byte[2:0] == 3'b110))
                     ? 3'h2 : 3'h0;
          if (s_q.opc[7:1] == 7'b1111011) begin
            case (q_byte[5:3])
              3'b000:  d.op = odct_pkg::op_test_imm_rm;
              3'b010:  d.op = odct_pkg::op_invert; // [RULE20]
              3'b011:  d.op = odct_pkg::op_negate; // [RULE10]
              3'b100:  d.op = odct_pkg::op_unsigned_multiply; // [RULE13]
              3'b101:  d.op = odct_pkg::op_signed_multiply; // [RULE14]
              3'b110:  d.op = odct_pkg::op_unsigned_divide;
              3'b111:  d.op = odct_pkg::op_signed_divide; // [RULE16]
              default: d.op = odct_pkg::op_none;
            endcase
          end
          if (d.op == odct_pkg::op_test_imm_rm) begin
            d.imm_n = s_q.w ? 3'h2 : 3'h1; // [RULE23]
          end else if (s_q.op == odct_pkg::op_signed_multiply_imm) begin
            d.imm_n = s_q.opc[1] ? 3'h1 : 3'h2; // [RULE15]
          end
          d.st = ((d.disp_n | d.imm_n) != 3'h0) ? odct_pkg::st_ext : odct_pkg::st_issue;
          // pointer loads need memory; segment moves keep reg bit 5 clear
          if ((d.op == odct_pkg::op_none) ||
              ((s_q.op == odct_pkg::op_load_pointer_data_seg ||
                s_q.op == odct_pkg::op_load_pointer_extra_seg) && !d.mem) || // [RULE6] [RULE7]
              ((s_q.op == odct_pkg::op_seg_load || s_q.op == odct_pkg::op_seg_store) &&
               q_byte[5])) begin
            d.illegal = 1'b1;
            d.seg_ovr = 1'b0;
            d.repeat_prefix     = 1'b0;
            d.st      = odct_pkg::st_opc;
          end
        end
      end
      odct_pkg::st_ext: begin
        if (acc) begin
          if (s_q.ext_idx < s_q.disp_n) begin
            if (s_q.ext_idx[0]) d.disp[15:8] = q_byte;
            else d.disp[7:0] = q_byte;
          end else if (s_q.ext_idx == s_q.disp_n) begin
            d.imm[7:0] = q_byte;
          end else begin
            d.imm[15:8] = q_byte;
          end
          d.ext_idx = s_q.ext_idx + 3'h1;
          if (d.ext_idx == s_q.disp_n + s_q.imm_n) d.st = odct_pkg::st_issue;
        end
      end
      odct_pkg::st_issue: begin
        if (s_q.disp_n == 3'h1) d.disp[15:8] = {8{s_q.disp[7]}};
        if (s_q.imm_n == 3'h1) begin
          d.imm[15:8] = (s_q.op == odct_pkg::op_signed_multiply_imm) ?
                        {8{s_q.imm[7]}} : 8'h00; // [RULE15] [RULE23]
        end
        d.load       = cyc_f(s_q.op, s_q.mem, s_q.w, s_q.repeat_prefix, count_reg);
        d.start      = 1'b1;
        d.exec_valid = 1'b1;
        d.st         = odct_pkg::st_exec;
      end
      odct_pkg::st_exec: begin
        if (tif.done) begin
          d.exec_done = 1'b1;
          d.st        = odct_pkg::st_opc;
          // prefixes live until the instruction they qualify finishes
          if (s_q.op != odct_pkg::op_seg_ovr) begin
            d.seg_ovr = 1'b0; // [RULE1]
            d.repeat_prefix     = 1'b0;
          end
        end
      end
      default: d.st = odct_pkg::st_opc;
    endcase
    d.q_ready = (d.st == odct_pkg::st_opc) || (d.st == odct_pkg::st_modrm) ||
                (d.st == odct_pkg::st_ext) || (d.st == odct_pkg::st_sub);
    d.busy    = (d.st == odct_pkg::st_exec);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= d;
    end
  end

  assign tif.start    = s_q.start;
  assign tif.load     = s_q.load;
  assign q_ready      = s_q.q_ready;
  assign exec_valid   = s_q.exec_valid;
  assign exec_op      = s_q.op;
  assign exec_word    = s_q.w;
  assign exec_mem     = s_q.mem;
  assign exec_seg_ovr = s_q.seg_ovr;
  assign exec_seg     = s_q.seg;
  assign exec_rep     = s_q.repeat_prefix;
  assign exec_modrm   = s_q.modrm;
  assign exec_disp    = s_q.disp;
  assign exec_imm     = s_q.imm;
  assign exec_cycles  = s_q.load;
  assign exec_done    = s_q.exec_done;
  assign exec_illegal = s_q.illegal;
  assign busy         = s_q.busy;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  seg_pfx_a: assert property (exec_valid && exec_op == odct_pkg::op_seg_ovr |-> // [RULE1]
      !exec_done ##2 exec_done && q_ready && exec_seg_ovr) else $error("prefix timing");
  seg_mem_a: assert property (exec_valid && exec_op == odct_pkg::op_seg_load && exec_mem // [RULE2]
      |-> ##9 exec_done) else $error("segment load time");
  seg_st_a: assert property (exec_valid && exec_op == odct_pkg::op_seg_store && exec_mem // [RULE3]
      |-> !exec_done [*8] ##4 exec_done) else $error("segment store time");
  table_translate_time_a: assert property (exec_valid && exec_op == odct_pkg::op_table_translate // [RULE4]
      |-> ##11 exec_done) else $error("translate time");
  lea_time_a: assert property (exec_valid && exec_op == odct_pkg::op_load_effective_address // [RULE5]
      |-> busy [*6] ##1 exec_done && !busy) else $error("address time");
  ptr_mem_a: assert property (exec_valid && exec_op == odct_pkg::op_load_pointer_data_seg // [RULE6]
      |-> exec_mem ##18 exec_done) else $error("pointer load");
  neg_mem_a: assert property (exec_valid && exec_op == odct_pkg::op_negate && exec_mem // [RULE10]
      |-> exec_cycles == 20'ha ##10 exec_done) else $error("negate time");
  mul_word_a: assert property (exec_valid && exec_op == odct_pkg::op_unsigned_multiply // [RULE13]
      && exec_mem && exec_word |-> ##41 exec_done) else $error("multiply time");
  signed_divide_byte_a: assert property (exec_valid && exec_op == odct_pkg::op_signed_divide // [RULE16]
      && !exec_mem && !exec_word |-> ##44 exec_done) else $error("divide time");
  rep_move_a: assert property (exec_valid && exec_op == odct_pkg::op_string_move && exec_rep // [RULE22]
      |-> exec_cycles == 20'h8 + {1'b0, $past(count_reg), 3'b000}) else $error("repeat count");
  acc_imm_a: assert property (exec_valid && exec_op == odct_pkg::op_test_acc && !exec_word // [RULE23]
      |-> exec_imm[15:8] == 8'h00 && exec_cycles == 20'h3) else $error("byte immediate");

  cov_prefix_c: cover property (exec_done && exec_op == odct_pkg::op_seg_ovr ##[1:40]
      exec_valid && exec_seg_ovr && exec_mem);
  cov_rep_c: cover property (exec_valid && exec_rep && exec_op == odct_pkg::op_string_move);
  cov_illegal_c: cover property (exec_illegal);
endmodule : odct_decoder
`default_nettype wire

//--- design/odct_map.svh
// Operation
// [RULE1] four segment override prefixes take 2 clocks and steer the next memory operand
// [RULE2] 8e with modrm loads a segment register: 2 register, 9 memory
// [RULE3] 8c with modrm stores a segment register: 2 register, 11 memory
// [RULE4] d7 replaces acc_low_byte with its table byte in 11 clocks
// [RULE5] 8d writes the effective address without memory access in 6 clocks
// [RULE6] c5 loads register and data_segment_reg in 18 clocks, memory only
// [RULE7] c4 loads register and extra_segment_reg in 18 clocks, memory only
// [RULE8] 9f copies low flags into acc_high_byte in 2 clocks
// [RULE9] 9e stores acc_high_byte into low flags in 3 clocks
// [RULE10] group f6/f7 reg 011 negates: 3 register, 10 memory
// [RULE11] 37 unpacked add adjust in 8 clocks
// [RULE12] 27 packed add adjust in 4 clocks
// [RULE13] group reg 100 unsigned multiply: 26-28 register byte, 41-43 memory word
// [RULE14] group reg 101 signed multiply: 25-28 register byte, 40-43 memory word
// [RULE15] 011010s1 three-operand signed multiply: 22-25 register, 29-32 memory; s byte immediate
// [RULE16] group reg 111 signed divide: 44-52 register byte, 59-67 memory word
// [RULE17] d5 0a unpacked adjust before divide in 15 clocks
// [RULE18] 98 sign-extends acc_low_byte into acc_word in 2 clocks
// [RULE19] 84/85 and a8/a9 update flags only, no result; 3/10 clocks; a8/a9 take 3 byte, 4 word
// [RULE20] group reg 010 inverts: 3 register, 10 memory
// [RULE21] a4/a5 moves one string element in 14 clocks
// [RULE22] repeat prefix repeats string move count_register times: 8 plus 8 per element
// [RULE23] opcode bit w selects byte or word and sizes the immediate
// [RULE24] counts are minimums: bytes queued, no waits, aligned words
`ifndef ODCT_MAP_SVH
`define ODCT_MAP_SVH
`define ODCT_PFX_SEG     8'b001??110
`define ODCT_PFX_REP     8'b1111001?
`define ODCT_OP_SEG_LD   8'h8e
`define ODCT_OP_SEG_ST   8'h8c
`define ODCT_OP_XLT      8'hd7
`define ODCT_OP_LEA      8'h8d
`define ODCT_OP_LDS      8'hc5
`define ODCT_OP_LES      8'hc4
`define ODCT_OP_F2AH     8'h9f
`define ODCT_OP_AH2F     8'h9e
`define ODCT_OP_UAA      8'h37
`define ODCT_OP_PAA      8'h27
`define ODCT_OP_UAD      8'hd5
`define ODCT_UAD_2ND     8'h0a
`define ODCT_OP_BSX      8'h98
`define ODCT_OP_TST_RM   8'b1000010?
`define ODCT_OP_TST_ACC  8'b1010100?
`define ODCT_OP_GRP      8'b1111011?
`define ODCT_OP_IMUL3    8'b011010?1
`define ODCT_OP_STRING_MOVE     8'b1010010?
`define ODCT_CYC_SEG_PFX 20'h2
`define ODCT_CYC_SEG_LDR 20'h2
`define ODCT_CYC_SEG_LDM 20'h9
`define ODCT_CYC_SEG_STR 20'h2
`define ODCT_CYC_SEG_STM 20'hb
`define ODCT_CYC_XLT     20'hb
`define ODCT_CYC_LEA     20'h6
`define ODCT_CYC_LPTR    20'h12
`define ODCT_CYC_F2AH    20'h2
`define ODCT_CYC_AH2F    20'h3
`define ODCT_CYC_UN_R    20'h3
`define ODCT_CYC_UN_M    20'ha
`define ODCT_CYC_UAA     20'h8
`define ODCT_CYC_PAA     20'h4
`define ODCT_CYC_MUL_RB  20'h1a
`define ODCT_CYC_MUL_RW  20'h23
`define ODCT_CYC_MUL_MB  20'h20
`define ODCT_CYC_MUL_MW  20'h29
`define ODCT_CYC_SIGNED_MULTIPLY_RB 20'h19
`define ODCT_CYC_SIGNED_MULTIPLY_RW 20'h22
`define ODCT_CYC_SIGNED_MULTIPLY_MB 20'h1f
`define ODCT_CYC_SIGNED_MULTIPLY_MW 20'h28
`define ODCT_CYC_IMI_R   20'h16
`define ODCT_CYC_IMI_M   20'h1d
`define ODCT_CYC_DIV_RB  20'h1d
`define ODCT_CYC_DIV_RW  20'h26
`define ODCT_CYC_DIV_MB  20'h23
`define ODCT_CYC_DIV_MW  20'h2c
`define ODCT_CYC_SIGNED_DIVIDE_RB 20'h2c
`define ODCT_CYC_SIGNED_DIVIDE_RW 20'h35
`define ODCT_CYC_SIGNED_DIVIDE_MB 20'h32
`define ODCT_CYC_SIGNED_DIVIDE_MW 20'h3b
`define ODCT_CYC_UAD     20'hf
`define ODCT_CYC_BSX     20'h2
`define ODCT_CYC_TIMM_R  20'h4
`define ODCT_CYC_TACC_B  20'h3
`define ODCT_CYC_TACC_W  20'h4
`define ODCT_CYC_STRING_MOVE    20'he
`define ODCT_CYC_REP_BAS 20'h8
`endif

//--- design/odct_pkg.sv
package odct_pkg;
  typedef enum logic [2:0] {st_opc, st_modrm, st_ext, st_sub, st_issue, st_exec} odct_state_e;
  typedef enum logic [4:0] {
    op_none, op_seg_ovr, op_seg_load, op_seg_store, op_table_translate,
    op_load_effective_address, op_load_pointer_data_seg, op_load_pointer_extra_seg,
    op_flags_to_high_acc, op_high_acc_to_flags, op_negate, op_unpacked_adjust_add,
    op_packed_adjust_add, op_unsigned_multiply, op_signed_multiply, op_signed_multiply_imm,
    op_unsigned_divide, op_signed_divide, op_unpacked_adjust_divide, op_byte_sign_extend,
    op_test_rm, op_test_acc, op_test_imm_rm, op_invert, op_string_move
  } odct_op_e;
  typedef struct packed {
    odct_state_e st;
    odct_op_e    op;
    logic [7:0]  opc;
    logic [7:0]  modrm;
    logic [15:0] disp;
    logic [15:0] imm;
    logic [2:0]  ext_idx;
    logic [2:0]  disp_n;
    logic [2:0]  imm_n;
    logic        w;
    logic        mem;
    logic        seg_ovr;
    logic [1:0]  seg;
    logic        repeat_prefix;
    logic        q_ready;
    logic        exec_valid;
    logic        exec_done;
    logic        illegal;
    logic        busy;
    logic        start;
    logic [19:0] load;
  } odct_dec_s;
  typedef struct packed {
    logic [19:0] cnt;
  } odct_tmr_s;
endpackage : odct_pkg

//--- design/odct_timer.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// execution cycle timer
// ****************************************
module odct_timer (
  input  wire logic   clk,   // processor clock
  input  wire logic   rst_n, // synchronous reset, active low
  odct_tmr_if.tmr     tif    // start, load, done
);
  odct_pkg::odct_tmr_s s_q;
  odct_pkg::odct_tmr_s s_d;

  // load n-1 so done lands one cycle early; the decoder registers it, giving n in total
  always_comb begin
    s_d = s_q;
    if (tif.start) begin
      s_d.cnt = tif.load - 20'h1;
    end else if (s_q.cnt != 20'h0) begin
      s_d.cnt = s_q.cnt - 20'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tif.done = (s_q.cnt == 20'h1);
endmodule : odct_timer
`default_nettype wire

//--- design/odct_tmr_if.sv
`timescale 1ns/10ps
`default_nettype none
interface odct_tmr_if;
  logic        start;
  logic [19:0] load;
  logic        done;
  modport ctl (output start, output load, input done);
  modport tmr (input start, input load, output done);
endinterface : odct_tmr_if
`default_nettype wire

//--- verif/odct_queue_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// prefetch queue model
// ****************************************
module odct_queue_model (
  input  wire logic       clk,     // processor clock
  input  wire logic       q_ready, // decoder takes the byte
  output var  logic       q_valid, // byte offered
  output var  logic [7:0] q_byte   // offered byte
);
  logic [7:0] fifo [$];
  logic       taken = 1'b0;
  initial q_valid = 1'b0;
  initial q_byte = 8'h00;
  task automatic push(input logic [7:0] b);
    fifo.push_back(b);
  endtask : push
  always @(posedge clk) taken <= q_valid && q_ready;
  // bytes are queued back to back, so issue counts stay at their minimum
  always @(negedge clk) begin
    if (taken) void'(fifo.pop_front());
    q_valid = fifo.size() != 0;
    // an idle line must not keep showing the last byte
    q_byte = q_valid ? fifo[0] : ~q_byte;
  end
endmodule : odct_queue_model
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s exp %0h got %0h", nm, e, g); end end
module testbench;
  logic               clk = 1'b0, rst_n = 1'b0;
  logic [15:0]        count_reg = 16'h0000;
  logic               q_valid, q_ready, ev, ew, em, eso, erep, done, ill, bsy, eso_v, erep_v;
  logic [7:0]         q_byte, modrm;
  logic [1:0]         seg;
  logic [15:0]        imm, disp;
  logic [19:0]        cyc;
  odct_pkg::odct_op_e op;
  int                 n_mismatch = 0, n_compared = 0, ticks = 0;
  initial forever #5 clk = ~clk;
  odct_queue_model u_q (.clk(clk), .q_ready(q_ready), .q_valid(q_valid), .q_byte(q_byte));
  odct_decoder u_dut (.clk(clk), .rst_n(rst_n), .q_valid(q_valid), .q_byte(q_byte),
    .count_reg(count_reg), .q_ready(q_ready), .exec_valid(ev), .exec_op(op), .exec_word(ew),
    .exec_mem(em), .exec_seg_ovr(eso), .exec_seg(seg), .exec_rep(erep), .exec_modrm(modrm),
    .exec_disp(disp), .exec_imm(imm), .exec_cycles(cyc), .exec_done(done), .exec_illegal(ill),
    .busy(bsy));
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    ticks++;
    if (ticks == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // feeds one instruction, first byte in b[7:0], then times issue to done
  task automatic issue(input logic [31:0] b, input int n, input logic [19:0] e_cyc);
    int k;
    for (int i = 0; i < n; i++) u_q.push(b[8*i+:8]);
    k = 0;
    while (ev !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    `CHK("exec_cycles", e_cyc, cyc)
    `CHK("busy", 1'b1, bsy)
    // prefix flags drop with exec_done, so they are judged while the instruction runs
    eso_v  = eso;
    erep_v = erep;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (done !== 1'b1 && k < 200);
    `CHK("done_delay", e_cyc, 20'(k))
  endtask : issue
  task automatic t_seg();
    logic [7:0] p [4] = '{8'h26, 8'h2e, 8'h36, 8'h3e};
    foreach (p[i]) begin
      issue({24'h0, p[i]}, 1, 20'h2);
      issue(32'h188e, 2, 20'h9);
      `CHK("exec_seg", p[i][4:3], seg)
      `CHK("exec_seg_ovr", 1'b1, eso_v)
    end
    issue(32'hc08c, 2, 20'h2);
    `CHK("exec_seg_ovr", 1'b0, eso)
    issue(32'h008c, 2, 20'hb);
  endtask : t_seg
  task automatic t_ops();
    issue(32'hd7, 1, 20'hb);
    `CHK("exec_op", odct_pkg::op_table_translate, op)
    issue(32'h008d, 2, 20'h6);
    issue(32'h00c5, 2, 20'h12);
    issue(32'h00c4, 2, 20'h12);
    issue(32'h9f, 1, 20'h2);
    issue(32'h9e, 1, 20'h3);
    issue(32'h37, 1, 20'h8);
    issue(32'h27, 1, 20'h4);
    issue(32'h0ad5, 2, 20'hf);
    issue(32'h98, 1, 20'h2);
    issue(32'hd8f6, 2, 20'h3);
    `CHK("exec_word", 1'b0, ew)
    issue(32'h18f7, 2, 20'ha);
    `CHK("exec_mem", 1'b1, em)
    issue(32'hd0f6, 2, 20'h3);
    issue(32'he0f6, 2, 20'h1a);
    issue(32'h8060f7, 3, 20'h29);
    `CHK("exec_modrm", 8'h60, modrm)
    `CHK("exec_disp", 16'hff80, disp)
    issue(32'he8f6, 2, 20'h19);
    issue(32'h28f7, 2, 20'h28);
    issue(32'hf8f6, 2, 20'h2c);
    issue(32'h38f7, 2, 20'h3b);
    issue(32'hffc06b, 3, 20'h16);
    `CHK("exec_imm", 16'hffff, imm)
    issue(32'h12340069, 4, 20'h1d);
    issue(32'h0085, 2, 20'ha);
    issue(32'h55a8, 2, 20'h3);
    `CHK("exec_imm", 16'h0055, imm)
    issue(32'h1234a9, 3, 20'h4);
    `CHK("exec_imm", 16'h1234, imm)
    issue(32'h07c0f6, 3, 20'h4);
    `CHK("exec_imm", 16'h0007, imm)
    issue(32'hf0f6, 2, 20'h1d);
  endtask : t_ops
  task automatic t_str();
    issue(32'ha5, 1, 20'he);
    count_reg = 16'h0003;
    issue(32'ha4f2, 2, 20'h20);
    `CHK("exec_rep", 1'b1, erep_v)
    count_reg = 16'h0000;
    issue(32'ha4f2, 2, 20'h8);
  endtask : t_str
  task automatic t_bad();
    int k;
    u_q.push(8'hc4);
    u_q.push(8'hc0);
    k = 0;
    while (ill !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    `CHK("exec_illegal", 1'b1, ill)
    issue(32'h98, 1, 20'h2);
  endtask : t_bad
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_seg();
    t_ops();
    t_str();
    t_bad();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
